/* logic/telepower_pkg.sv */
// constants and types for the tele-powering mode sequencer
`default_nettype none
package telepower_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int TOG_HZ = 50_000;           // toggling repetition rate
  localparam int PW_SHORT_NS = 2200;        // short pulse width
  localparam int PW_LONG_NS = 3400;         // long pulse width
  localparam int DL_BIT_HZ = 564_480;       // down-link nominal bit rate
  localparam int PERIOD_CYC = CLK_HZ / TOG_HZ;
  localparam int PW_SHORT_CYC = (PW_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PW_LONG_CYC = (PW_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_CYC = CLK_HZ / DL_BIT_HZ;
  // ---------------------------------------------------------------
  // widths and block lengths
  // ---------------------------------------------------------------
  localparam int CNT_W = 11;
  localparam int TMR_W = 8;
  localparam int ADDR_W = 10;
  localparam int LEN_W = 20;
  localparam int BLK_SHORT = 341;
  localparam int BLK_LONG = 1023;
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] PW_SHORT = CNT_W'(PW_SHORT_CYC);
  localparam logic [CNT_W-1:0] PW_LONG = CNT_W'(PW_LONG_CYC);
  localparam logic [TMR_W-1:0] BIT_LAST = TMR_W'(BIT_CYC - 1);
  localparam logic [ADDR_W-1:0] SHORT_LAST = ADDR_W'(BLK_SHORT - 1);
  localparam logic [ADDR_W-1:0] LONG_LAST = ADDR_W'(BLK_LONG - 1);
  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic RST_DL_BIT = 1'b1;       // unmodulated high amplitude
  localparam logic RST_TOGGLE_EN = 1'b0;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DRAIN = 2'b01,
    ST_SEND = 2'b10
  } state_t;
  typedef struct packed {
    state_t state;
    logic toggle_en;
    logic reen_pend;
    logic phase;
    logic mod_pulse;
    logic blk_long;
    logic dl_bit;
    logic [CNT_W-1:0] pwm_cnt;
    logic [TMR_W-1:0] bit_tmr;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] bits_left;
  } seq_t;
endpackage
`default_nettype wire

/* logic/telegram_mem_if.sv */
// link between the sequencer and its telegram memory
`default_nettype none
interface telegram_mem_if;
  import telepower_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

/* logic/telegram_mem.sv */
// one-bit-wide telegram store with registered read
`default_nettype none
module telegram_mem (
  input wire logic clock_in,
  telegram_mem_if.mem port_in
);
  import telepower_pkg::*;
  logic store [0:(1<<ADDR_W)-1];
  logic rd_q;
  // --------------------------------------------------------------
  // write port and registered read
  // --------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (port_in.wr_en) begin
      store[port_in.wr_addr] <= port_in.wr_data;
    end
    rd_q <= store[port_in.rd_addr];
  end
  assign port_in.rd_data = rd_q;
endmodule
`default_nettype wire

/* logic/telepower_mode_sequencer.sv */
// tele-powering toggling and down-link mode sequencer
// ----------------------------------------------------------------
// Behaviour
// - interoperable mode: 50 kHz toggling pulse modulation
// - toggling switched off before down-link starts
// - toggling back on only if commanded
// - mode changes need no transponder handshake
// - BCH block of 341 or 1023 bits
// - block repeated cyclically, start found by check
// - toggling rate 50 kHz within 200 ppm
// - pulse width between 2.0 and 3.5 us
// - widths alternate, differing by 1.2 us
// ----------------------------------------------------------------
`default_nettype none
module telepower_mode_sequencer (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic interop_mode_in,
  input wire logic toggle_on_cmd_in,
  input wire logic toggle_off_cmd_in,
  input wire logic dl_start_in,
  input wire logic dl_stop_in,
  input wire logic [telepower_pkg::LEN_W-1:0] dl_bits_in,
  input wire logic long_block_in,
  input wire logic wr_en_in,
  input wire logic [telepower_pkg::ADDR_W-1:0] wr_addr_in,
  input wire logic wr_data_in,
  output logic mod_pulse_out,
  output logic dl_bit_out,
  output logic dl_active_out,
  output logic toggle_en_out
);
  import telepower_pkg::*;

  localparam int DRAIN_MAX = 400;

  seq_t s_q;
  seq_t s_d;
  logic bit_due;
  logic dl_end;
  telegram_mem_if mem_bus ();

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // pulse width for the current phase
  function automatic logic [CNT_W-1:0] pulse_len(input logic ph);
    pulse_len = ph ? PW_LONG : PW_SHORT;
  endfunction

  // last address of the selected block length
  function automatic logic [ADDR_W-1:0] blk_last(input logic lng);
    blk_last = lng ? LONG_LAST : SHORT_LAST;
  endfunction

  // --------------------------------------------------------------
  // telegram memory
  // --------------------------------------------------------------
  assign mem_bus.wr_en = wr_en_in;
  assign mem_bus.wr_addr = wr_addr_in;
  assign mem_bus.wr_data = wr_data_in;
  assign mem_bus.rd_addr = s_q.addr;

  telegram_mem mem_u (
    .clock_in(clock_in),
    .port_in(mem_bus)
  );

  assign bit_due = (s_q.state == ST_SEND) && (s_q.bit_tmr == '0);
  assign dl_end = (s_q.state == ST_SEND) &&
                  (dl_stop_in || (bit_due && s_q.bits_left == '0));

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // free-running period counter keeps the on-edge in phase
    s_d.pwm_cnt = (s_q.pwm_cnt == PERIOD_LAST) ? '0 :
                  CNT_W'(s_q.pwm_cnt + 1'b1);
    // pulse opens at period start, runs its full width
    if (s_q.pwm_cnt == '0) begin
      s_d.mod_pulse = s_q.toggle_en && interop_mode_in;
    end else if (s_q.mod_pulse && s_q.pwm_cnt == pulse_len(s_q.phase)) begin
      s_d.mod_pulse = 1'b0;
      s_d.phase = ~s_q.phase;
    end
    case (s_q.state)
      ST_IDLE: begin
        // direct toggle commands, set wins over clear
        if (toggle_on_cmd_in) begin
          s_d.toggle_en = 1'b1;
        end else if (toggle_off_cmd_in) begin
          s_d.toggle_en = 1'b0;
        end
        if (dl_start_in) begin
          s_d.state = ST_DRAIN;
          s_d.bits_left = dl_bits_in;
          s_d.blk_long = long_block_in;
          s_d.reen_pend = 1'b0;
        end
      end
      ST_DRAIN: begin
        // start held until no pulse can begin
        if (!s_q.mod_pulse && s_q.pwm_cnt != '0) begin
          s_d.toggle_en = 1'b0;
          s_d.state = ST_SEND;
          s_d.addr = '0;
          s_d.bit_tmr = BIT_LAST;
        end
      end
      ST_SEND: begin
        s_d.bit_tmr = (s_q.bit_tmr == '0) ? BIT_LAST :
                      TMR_W'(s_q.bit_tmr - 1'b1);
        if (bit_due && s_q.bits_left != '0) begin
          s_d.dl_bit = mem_bus.rd_data;
          s_d.bits_left = LEN_W'(s_q.bits_left - 1'b1);
          // cyclic repetition of the block
          s_d.addr = (s_q.addr == blk_last(s_q.blk_long)) ? '0 :
                     ADDR_W'(s_q.addr + 1'b1);
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
    // re-enable command latched while down-link is pending
    if (s_q.state != ST_IDLE) begin
      if (toggle_on_cmd_in) begin
        s_d.reen_pend = 1'b1;
      end else if (toggle_off_cmd_in) begin
        s_d.reen_pend = 1'b0;
      end
    end
    if (dl_end) begin
      s_d.state = ST_IDLE;
      s_d.dl_bit = RST_DL_BIT;
      s_d.toggle_en = s_q.reen_pend || toggle_on_cmd_in;
      s_d.reen_pend = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.toggle_en <= RST_TOGGLE_EN;
      s_q.dl_bit <= RST_DL_BIT;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign mod_pulse_out = s_q.mod_pulse;
  assign dl_bit_out = s_q.dl_bit;
  assign dl_active_out = (s_q.state == ST_SEND);
  assign toggle_en_out = s_q.toggle_en;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [CNT_W-1:0] plen_q;
  logic [CNT_W-1:0] prev_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      plen_q <= '0;
      prev_q <= '0;
    end else if (s_q.mod_pulse) begin
      plen_q <= CNT_W'(plen_q + 1'b1);
    end else if (plen_q != '0) begin
      prev_q <= plen_q;
      plen_q <= '0;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  pulse_width_a: assert property ($fell(s_q.mod_pulse) |->
    (plen_q == PW_SHORT || plen_q == PW_LONG))
    else $error("toggling pulse width out of range");
  pulse_alternate_a: assert property (
    ($fell(s_q.mod_pulse) && prev_q != '0) |-> plen_q != prev_q)
    else $error("pulse widths do not alternate");
  pulse_phase_a: assert property (
    $rose(s_q.mod_pulse) |-> s_q.pwm_cnt == 1)
    else $error("pulse start not on period boundary");
  pulse_interop_a: assert property (
    $rose(s_q.mod_pulse) |-> $past(interop_mode_in) && $past(s_q.toggle_en))
    else $error("pulse without interoperable toggling");
  send_quiet_a: assert property (
    dl_active_out |-> !s_q.mod_pulse && !s_q.toggle_en)
    else $error("toggling active during down-link");
  drain_bound_a: assert property (
    s_q.state == ST_DRAIN |-> ##[0:DRAIN_MAX] s_q.state == ST_SEND)
    else $error("start request never served");
  start_taken_a: assert property (
    (s_q.state == ST_IDLE && dl_start_in) |=> s_q.state == ST_DRAIN)
    else $error("start request not taken");
  reenable_on_a: assert property (
    (dl_end && s_q.reen_pend) |=> s_q.toggle_en && !dl_active_out)
    else $error("commanded re-enable lost");
  reenable_off_a: assert property (
    (dl_end && !s_q.reen_pend && !toggle_on_cmd_in) |=> !s_q.toggle_en)
    else $error("toggling resumed without command");
  block_wrap_a: assert property (
    (bit_due && s_q.bits_left != '0 && s_q.addr == blk_last(s_q.blk_long))
    |=> s_q.addr == '0)
    else $error("block does not repeat cyclically");

  send_seen_c: cover property (s_q.state == ST_DRAIN ##[1:DRAIN_MAX]
    dl_active_out);
  toggle_seen_c: cover property ($fell(s_q.mod_pulse) && prev_q != '0);
  reenable_seen_c: cover property (dl_end && s_q.reen_pend);
endmodule
`default_nettype wire

/* tb/transponder_model.sv */
// wayside transponder model measuring the toggling pulses
`default_nettype none
module transponder_model (
  input wire logic clock_in,
  input wire logic mod_pulse_in,
  output int width_out,
  output int period_out,
  output int pulses_out,
  output logic uplink_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int run = 0;
  int gap = 0;
  // up-link runs whenever the carrier is on; nothing goes back
  assign uplink_out = !mod_pulse_in;
  // high width of each pulse and rise-to-rise period
  always @(posedge clock_in) begin
    gap <= gap + 1;
    if (mod_pulse_in) run <= run + 1;
    if (mod_pulse_in && run == 0) begin
      period_out <= gap;
      gap <= 1;
    end
    if (!mod_pulse_in && run != 0) begin
      width_out <= run;
      pulses_out <= pulses_out + 1;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

/* tb/test_telepower_mode_sequencer.sv */
// self-checking bench for the mode sequencer
`default_nettype none
module test_telepower_mode_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import telepower_pkg::*;
  typedef struct {logic on; logic off; logic en;} row_t;
  row_t rows [4] = '{'{1, 0, 1}, '{0, 1, 0}, '{1, 1, 1}, '{0, 1, 0}};
  int ad [6] = '{0, 1, 2, 3, 340, 341};
  logic [5:0] pat = 6'b110110;
  logic img [1024];
  logic clock_in = 0;
  logic rst_in, interop, on, off, start, stop, long_blk, wr_en, wr_data;
  logic [LEN_W-1:0] bits;
  logic [ADDR_W-1:0] wr_addr;
  logic pulse, dl_bit, act, en, uplink;
  int width, period, pulses, w1, w2, p;
  int errors = 0;
  int checks_done = 0;
  always #5 clock_in = ~clock_in;
  telepower_mode_sequencer u_telepower_mode_sequencer (
    .clock_in(clock_in), .rst_in(rst_in), .interop_mode_in(interop),
    .toggle_on_cmd_in(on), .toggle_off_cmd_in(off),
    .dl_start_in(start), .dl_stop_in(stop), .dl_bits_in(bits),
    .long_block_in(long_blk), .wr_en_in(wr_en), .wr_addr_in(wr_addr),
    .wr_data_in(wr_data), .mod_pulse_out(pulse), .dl_bit_out(dl_bit),
    .dl_active_out(act), .toggle_en_out(en)
  );
  transponder_model u_transponder_model (
    .clock_in(clock_in), .mod_pulse_in(pulse), .width_out(width),
    .period_out(period), .pulses_out(pulses), .uplink_out(uplink)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // one-cycle kernel command pulses
  task automatic cmd(input logic a, input logic b, input logic c,
                     input logic d);
    @(posedge clock_in);
    {on, off, start, stop} <= {a, b, c, d};
    @(posedge clock_in);
    {on, off, start, stop} <= 4'h0;
    #1;
  endtask
  task automatic next_pulse();
    p = pulses;
    for (int i = 0; i < 2500 && pulses == p; i++) cyc(1);
    if (pulses == p) begin
      errors++;
      conclude();
    end
  endtask
  task automatic wait_act();
    for (int i = 0; i < 3000 && act !== 1'b1; i++) cyc(1);
    if (act !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask
  // start a transfer, check lead-in, bits and the end
  task automatic run_dl(input int n, input logic reen);
    @(posedge clock_in);
    bits <= LEN_W'(n);
    cmd(0, 0, 1, 0);
    wait_act();
    check(en, 0);
    check(pulse, 0);
    if (reen) cmd(1, 0, 1, 0);
    cyc(reen ? 86 : 88);
    check(dl_bit, 1);
    check(en, 0);
    for (int i = 0; i < n; i++) begin
      cyc(177);
      check(dl_bit, img[i]);
    end
    cyc(88);
    check(act, 1);
    cyc(1);
    check({act, dl_bit}, 2'b01);
    cyc(1);
    check(en, reen);
  endtask
  initial begin
    rst_in = 1;
    {interop, on, off, start, stop, long_blk, wr_en, wr_data} = 8'h00;
    bits = '0;
    wr_addr = '0;
    repeat (5) @(posedge clock_in);
    rst_in <= 0;
    #1;
    check({pulse, dl_bit, act, en}, 4'h4);
    foreach (rows[k]) begin
      cmd(rows[k].on, rows[k].off, 0, 0);
      check(en, rows[k].en);
    end
    $display("done: commands");
    for (int k = 0; k < 6; k++) begin
      @(posedge clock_in);
      {wr_en, wr_addr, wr_data} <= {1'b1, ADDR_W'(ad[k]), pat[k]};
      img[ad[k]] = pat[k];
      @(posedge clock_in);
      wr_en <= 0;
    end
    @(posedge clock_in);
    interop <= 1;
    cmd(1, 0, 0, 0);
    next_pulse();
    next_pulse();
    w1 = width;
    next_pulse();
    w2 = width;
    check(w1 == 220 || w1 == 340, 1);
    check(w1 + w2, 560);
    check(w1 > w2 ? w1 - w2 : w2 - w1, 120);
    check(period, 2000);
    check(uplink, !pulse);
    $display("done: toggling");
    run_dl(4, 0);
    run_dl(0, 1);
    $display("done: down-link");
    @(posedge clock_in);
    bits <= LEN_W'(400);
    cmd(0, 0, 1, 0);
    wait_act();
    cyc(177 * 341 + 88);
    check(dl_bit, img[340]);
    cyc(177);
    check(dl_bit, img[0]);
    cmd(0, 0, 0, 1);
    check(act, 0);
    $display("done: wrap");
    @(posedge clock_in);
    interop <= 0;
    // toggling enabled again, so only the mode select can hold pulses off
    cmd(1, 0, 0, 0);
    check(en, 1);
    cyc(2100);
    p = pulses;
    cyc(2100);
    check(pulses, p);
    $display("done: interop off");
    conclude();
  end
endmodule
`default_nettype wire
